//--- rtl/adc_glue_pkg.sv
// Purpose: constants shared by the converter bus glue
// Assumes: one 10 MHz core clock
// Notes: no registers reachable by software
package adc_glue_pkg;

  // ----------------------------------------
  // clock
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000; // core clock rate

  // ----------------------------------------
  // io mode decode fields
  // ----------------------------------------
  localparam int IO_FN_HI = 15; // decoded select line, upper
  localparam int IO_FN_LO = 14; // decoded select line, lower
  localparam int IO_CH_HI = 11; // channel bits in duplicated port address
  localparam int IO_CH_LO = 8;

  // ----------------------------------------
  // memory mode decode fields
  // ----------------------------------------
  localparam int MEM_BLK_HI = 15; // top four lines pick a 4k block
  localparam int MEM_BLK_LO = 12;
  localparam logic [3:0] MEM_BLK_VAL = 4'hf;
  localparam int MEM_EXT_BIT = 11; // extended pattern needs this bit clear
  localparam logic MEM_EXT_VAL = 1'b0;
  localparam int MEM_FN_HI = 5; // function field
  localparam int MEM_FN_LO = 4;
  localparam int MEM_CH_HI = 3; // channel field
  localparam int MEM_CH_LO = 0;

  // ----------------------------------------
  // functions and status layout
  // ----------------------------------------
  localparam logic [1:0] FN_LATCH = 2'h0; // latch write / status read
  localparam logic [1:0] FN_START = 2'h1; // start write / data read
  localparam int STATUS_BIT = 0; // eoc position on a status read
  localparam logic [7:0] DATA_IDLE = 8'h00;

  // ----------------------------------------
  // bus cycle states, gray except the recover to idle step
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_RECOVER = 2'h3
  } cyc_state_t;

endpackage

//--- rtl/pin_sync2.sv
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: grouped bits are stable around the strobe that qualifies them
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r; // first stage, may go metastable

  // ----------------------------------------
  // two stages, synchronous reset to zero
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- rtl/cpu_adc_bus_interface.sv
// Purpose: glue between a processor bus and a 16 channel converter
// Assumes: bus pins asynchronous to CORE_CLK, sampled through two flops
// Notes: pulses trail the strobes by the synchroniser delay plus the output register
`timescale 1ns/100ps
`default_nettype none
module cpu_adc_bus_interface
  import adc_glue_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic MODE_MEM,
  input wire logic MEM_EXTENDED,
  input wire logic IRQ_DIRECT,
  input wire logic ACK_QUALIFY,
  input wire logic CHAN_FROM_ADDR,
  input wire logic [15:0] CPU_ADDR,
  input wire logic CPU_RD_N,
  input wire logic CPU_WR_N,
  input wire logic CPU_IO_M,
  input wire logic CPU_RW,
  input wire logic PHI2,
  input wire logic VALID_MEMORY_CYCLE,
  input wire logic [7:0] CPU_DATA_IN,
  output logic [7:0] CPU_DATA_OUT,
  output logic CPU_DATA_OE_N,
  input wire logic CPU_INTERRUPT_ACK_N,
  output logic CPU_INTERRUPT_REQUEST_N,
  input wire logic CONV_EOC,
  output logic CONV_ALE,
  output logic CONV_START,
  output logic CONV_OE,
  output logic [3:0] CONV_CHAN
);

  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  logic [15:0] addr_s; // address after two flops
  logic [7:0] din_s; // write data after two flops
  logic [4:0] mode_s; // static straps
  logic [7:0] ctl_s; // bus control lines
  logic mode_mem; // memory mapped processor
  logic mem_ext; // extended memory pattern
  logic irq_direct; // eoc drives request directly
  logic ack_qual; // acknowledge qualified by eoc
  logic chan_addr; // channel from address bus
  logic rd_n_s;
  logic wr_n_s;
  logic io_m_s;
  logic rw_s;
  logic phi2_s;
  logic vma_s;
  logic ack_n_s;
  logic eoc_s;

  pin_sync2 #(.WIDTH(16)) u_sync_addr (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d(CPU_ADDR),
    .q(addr_s)
  );

  pin_sync2 #(.WIDTH(8)) u_sync_data (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d(CPU_DATA_IN),
    .q(din_s)
  );

  pin_sync2 #(.WIDTH(5)) u_sync_mode (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({MODE_MEM, MEM_EXTENDED, IRQ_DIRECT, ACK_QUALIFY, CHAN_FROM_ADDR}),
    .q(mode_s)
  );

  // active-low lines are inverted before and after so reset reads inactive
  // eoc too: reset then reads it done, its idle level, so no false rise after reset
  pin_sync2 #(.WIDTH(8)) u_sync_ctl (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({~CPU_RD_N, ~CPU_WR_N, CPU_IO_M, CPU_RW, PHI2, VALID_MEMORY_CYCLE,
        ~CPU_INTERRUPT_ACK_N, ~CONV_EOC}),
    .q(ctl_s)
  );

  assign {mode_mem, mem_ext, irq_direct, ack_qual, chan_addr} = mode_s;
  assign rd_n_s = ~ctl_s[7];
  assign wr_n_s = ~ctl_s[6];
  assign io_m_s = ctl_s[5];
  assign rw_s = ctl_s[4];
  assign phi2_s = ctl_s[3];
  assign vma_s = ctl_s[2];
  assign ack_n_s = ~ctl_s[1];
  assign eoc_s = ~ctl_s[0];

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns {hit, function}; used at cycle entry only, the hold test looks at the strobe alone
  function automatic logic [2:0] decode(input logic mem, input logic ext,
                                        input logic [15:0] a);
    logic hit;
    logic [1:0] fn;
    hit = 1'b0;
    fn = FN_LATCH;
    if (mem) begin
      hit = (a[MEM_BLK_HI:MEM_BLK_LO] == MEM_BLK_VAL);
      if (ext) begin
        hit = hit && (a[MEM_EXT_BIT] == MEM_EXT_VAL);
        fn = a[MEM_FN_HI:MEM_FN_LO];
      end
    end else begin
      // port address duplicated on upper lines, no latch needed
      hit = 1'b1;
      fn = a[IO_FN_HI:IO_FN_LO];
    end
    return {hit, fn};
  endfunction

  logic [2:0] dec; // decode of the current address
  logic hit; // address selects the converter
  logic [1:0] fn; // decoded function
  logic acc_rd; // qualified read strobe
  logic acc_wr; // qualified write strobe
  logic [3:0] chan_src; // channel from the address bus

  assign dec = decode(mode_mem, mem_ext, addr_s);
  assign hit = dec[2];
  assign fn = dec[1:0];

  // ----------------------------------------
  // strobe qualification
  // ----------------------------------------
  always_comb begin
    if (mode_mem) begin
      acc_rd = phi2_s && vma_s && rw_s;
      acc_wr = phi2_s && vma_s && !rw_s;
      chan_src = addr_s[MEM_CH_HI:MEM_CH_LO];
    end else begin
      acc_rd = !rd_n_s && io_m_s;
      acc_wr = !wr_n_s && io_m_s;
      chan_src = addr_s[IO_CH_HI:IO_CH_LO];
    end
  end

  // ----------------------------------------
  // bus cycle state machine
  // ----------------------------------------
  cyc_state_t state_r; // current cycle state
  cyc_state_t state_nxt;
  logic is_wr_r; // captured direction of the cycle
  logic [1:0] fn_r; // captured function
  logic simple_r; // captured simple memory variant
  logic start_cyc; // a decoded strobe begins
  logic strobe_on; // the captured strobe is still active

  assign start_cyc = hit && (acc_rd || acc_wr);
  assign strobe_on = is_wr_r ? acc_wr : acc_rd;

  // next state: pulses track the strobe, then one idle cycle
  always_comb begin
    case (state_r)
      ST_IDLE: begin
        state_nxt = start_cyc ? ST_ACTIVE : ST_IDLE;
      end
      ST_ACTIVE: begin
        state_nxt = strobe_on ? ST_ACTIVE : ST_RECOVER;
      end
      ST_RECOVER: begin
        // wait for the strobe to fall so one access makes one pulse
        state_nxt = (acc_rd || acc_wr) ? ST_RECOVER : ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // capture direction and function at cycle entry
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      is_wr_r <= 1'b0;
      fn_r <= FN_LATCH;
      simple_r <= 1'b0;
    end else if (state_r == ST_IDLE && start_cyc) begin
      is_wr_r <= acc_wr;
      fn_r <= fn;
      simple_r <= mode_mem && !mem_ext;
    end
  end

  // ----------------------------------------
  // converter pulses
  // ----------------------------------------
  logic ent; // entering the active state this edge
  logic ent_wr; // decoded write entering
  logic ent_rd; // decoded read entering
  logic act_nxt; // active state next cycle
  logic ale_nxt;
  logic start_nxt;
  logic oe_nxt;
  logic stat_nxt;
  logic wr_k; // kind of the cycle going on
  logic [1:0] fn_k;
  logic simple_k;

  assign ent = (state_r == ST_IDLE) && start_cyc;
  assign wr_k = ent ? acc_wr : is_wr_r;
  assign fn_k = ent ? fn : fn_r;
  assign simple_k = ent ? (mode_mem && !mem_ext) : simple_r;
  assign act_nxt = (state_nxt == ST_ACTIVE);
  assign ent_wr = ent && acc_wr;
  assign ent_rd = ent && acc_rd;

  // simple memory variant: one decode pulse gates latch+start and oe
  always_comb begin
    ale_nxt = act_nxt && wr_k && (simple_k || fn_k == FN_LATCH);
    start_nxt = act_nxt && wr_k && (simple_k || fn_k == FN_START);
    oe_nxt = act_nxt && !wr_k && (simple_k || fn_k == FN_START);
    stat_nxt = act_nxt && !wr_k && !simple_k && fn_k == FN_LATCH;
  end

  logic ale_r;
  logic start_r;
  logic oe_r;
  logic data_oe_n_r; // status drive enable, active low
  logic [3:0] chan_r;
  logic [7:0] dout_r;

  // pulses lasting the strobe, positive except the active-low status drive enable
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ale_r <= 1'b0;
      start_r <= 1'b0;
      oe_r <= 1'b0;
      data_oe_n_r <= 1'b1;
    end else begin
      ale_r <= ale_nxt;
      start_r <= start_nxt;
      oe_r <= oe_nxt;
      data_oe_n_r <= !stat_nxt;
    end
  end

  // channel loaded on the same edge the latch pulse rises
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      chan_r <= 4'h0;
    end else if (ent_wr && (simple_k || fn == FN_LATCH)) begin
      chan_r <= chan_addr ? chan_src : din_s[3:0];
    end
  end

  // status byte: eoc in one bit, the rest zero
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      dout_r <= DATA_IDLE;
    end else if (stat_nxt) begin
      dout_r <= DATA_IDLE; // other bits read as zero
      dout_r[STATUS_BIT] <= eoc_s;
    end else begin
      dout_r <= DATA_IDLE;
    end
  end

  // ----------------------------------------
  // interrupt flag
  // ----------------------------------------
  logic eoc_d_r; // eoc one cycle later, for the rise
  logic irq_ff_r; // latched end of conversion
  logic irq_n_r; // request pin, active low
  logic eoc_rise;
  logic ack_clr;
  logic stat_clr;

  assign eoc_rise = eoc_s && !eoc_d_r;
  // qualifying stops another source's acknowledge clearing this request
  assign ack_clr = !ack_n_s && (!ack_qual || eoc_s);
  assign stat_clr = ent_rd && !simple_k && fn == FN_LATCH;

  // set wins over clear so a new end of conversion is not lost
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      eoc_d_r <= 1'b1; // matches the synchronised eoc during reset
      irq_ff_r <= 1'b0;
    end else begin
      eoc_d_r <= eoc_s;
      if (eoc_rise) begin
        irq_ff_r <= 1'b1;
      end else if (ack_clr || stat_clr) begin
        irq_ff_r <= 1'b0;
      end
    end
  end

  // direct mode follows eoc, cleared only when a new conversion drops it
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      irq_n_r <= 1'b1;
    end else if (irq_direct) begin
      irq_n_r <= !eoc_s;
    end else begin
      irq_n_r <= !irq_ff_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign CONV_ALE = ale_r;
  assign CONV_START = start_r;
  assign CONV_OE = oe_r;
  assign CONV_CHAN = chan_r;
  assign CPU_DATA_OUT = dout_r;
  // no converter clock leaves this block; it comes from its own source
  assign CPU_DATA_OE_N = data_oe_n_r; // low while glue drives the bus
  assign CPU_INTERRUPT_REQUEST_N = irq_n_r;

endmodule
`default_nettype wire

//--- test/cpu_adc_bus_interface_props.sv
// Purpose: port-level checks of the converter bus glue
// Assumes: straps change only while reset is held
// Notes: pulses trail their strobe by three edges, the latched request by four
`timescale 1ns/100ps
`default_nettype none
module cpu_adc_bus_interface_chk (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic MODE_MEM,
  input wire logic MEM_EXTENDED,
  input wire logic IRQ_DIRECT,
  input wire logic ACK_QUALIFY,
  input wire logic CHAN_FROM_ADDR,
  input wire logic [15:0] CPU_ADDR,
  input wire logic CPU_RD_N,
  input wire logic CPU_WR_N,
  input wire logic CPU_IO_M,
  input wire logic CPU_RW,
  input wire logic PHI2,
  input wire logic VALID_MEMORY_CYCLE,
  input wire logic [7:0] CPU_DATA_IN,
  input wire logic [7:0] CPU_DATA_OUT,
  input wire logic CPU_DATA_OE_N,
  input wire logic CPU_INTERRUPT_ACK_N,
  input wire logic CPU_INTERRUPT_REQUEST_N,
  input wire logic CONV_EOC,
  input wire logic CONV_ALE,
  input wire logic CONV_START,
  input wire logic CONV_OE,
  input wire logic [3:0] CONV_CHAN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // ----------------------------------------
  // expected causes, straight from the pins
  // ----------------------------------------
  logic [1:0] fn;
  logic hit, wr, rd, simple, ale_c, st_c, oe_c, stat_c, post;
  logic [2:0] rcnt_r; // edges since reset, saturating
  always_comb begin
    fn = MODE_MEM ? CPU_ADDR[5:4] : CPU_ADDR[15:14];
    hit = MODE_MEM & PHI2 & VALID_MEMORY_CYCLE & (CPU_ADDR[15:12] == 4'hf)
      & (!MEM_EXTENDED | !CPU_ADDR[11]);
    wr = (!MODE_MEM & !CPU_WR_N & CPU_IO_M) | (hit & !CPU_RW);
    rd = (!MODE_MEM & !CPU_RD_N & CPU_IO_M) | (hit & CPU_RW);
    simple = MODE_MEM & !MEM_EXTENDED;
    ale_c = wr & (simple | fn == 2'h0);
    st_c = wr & (simple | fn == 2'h1);
    oe_c = rd & (simple | fn == 2'h1);
    stat_c = rd & !simple & fn == 2'h0;
    post = rcnt_r == 3'h4;
  end
  // history before reset must not be judged
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) rcnt_r <= 3'h0;
    else if (rcnt_r != 3'h4) rcnt_r <= rcnt_r + 3'h1;
  end
  chk_ale_shift: assert property (post |-> CONV_ALE == $past(ale_c, 3))
    else $error("latch pulse off its strobe");
  chk_start_shift: assert property (post |-> CONV_START == $past(st_c, 3))
    else $error("start pulse off its strobe");
  chk_oe_read_only: assert property (post |-> CONV_OE == $past(oe_c, 3))
    else $error("output enable off its read");
  chk_status_drive: assert property (post |-> !CPU_DATA_OE_N == $past(stat_c, 3))
    else $error("status drive off its read");
  chk_status_value: assert property (post && !CPU_DATA_OE_N |->
      CPU_DATA_OUT == {7'h00, $past(CONV_EOC, 3)})
    else $error("status byte wrong");
  // two synchroniser flops, the flag, then the request flop
  chk_irq_set: assert property (post && !IRQ_DIRECT && $rose(CONV_EOC)
      |-> ##4 !CPU_INTERRUPT_REQUEST_N)
    else $error("request not raised");
  chk_ack_clears: assert property (post && !IRQ_DIRECT && !ACK_QUALIFY
      && !CPU_INTERRUPT_ACK_N && !CPU_INTERRUPT_REQUEST_N
      |-> ##[1:5] CPU_INTERRUPT_REQUEST_N)
    else $error("acknowledge did not clear");
  chk_ack_qualified: assert property (post && !IRQ_DIRECT && ACK_QUALIFY
      && !CPU_INTERRUPT_REQUEST_N && !$past(CONV_EOC, 2) && !$past(CONV_EOC, 3)
      && !$past(stat_c, 2) && !$past(stat_c, 3) |=> !CPU_INTERRUPT_REQUEST_N)
    else $error("unqualified acknowledge cleared");
  chk_direct_irq: assert property (post && IRQ_DIRECT
      |-> CPU_INTERRUPT_REQUEST_N == !$past(CONV_EOC, 3))
    else $error("direct request wrong");
  chk_chan_latch: assert property ($rose(CONV_ALE) |->
      CONV_CHAN == (CHAN_FROM_ADDR ?
      (MODE_MEM ? $past(CPU_ADDR[3:0], 3) : $past(CPU_ADDR[11:8], 3))
      : $past(CPU_DATA_IN[3:0], 3)))
    else $error("channel not captured");
  cov_ale: cover property ($rose(CONV_ALE));
  cov_oe: cover property ($rose(CONV_OE));
  cov_irq: cover property ($fell(CPU_INTERRUPT_REQUEST_N));
endmodule
bind cpu_adc_bus_interface cpu_adc_bus_interface_chk cpu_adc_bus_interface_chk_i (.CORE_CLK,
  .RST_B, .MODE_MEM, .MEM_EXTENDED, .IRQ_DIRECT, .ACK_QUALIFY, .CHAN_FROM_ADDR, .CPU_ADDR,
  .CPU_RD_N, .CPU_WR_N, .CPU_IO_M, .CPU_RW, .PHI2, .VALID_MEMORY_CYCLE, .CPU_DATA_IN,
  .CPU_DATA_OUT, .CPU_DATA_OE_N, .CPU_INTERRUPT_ACK_N, .CPU_INTERRUPT_REQUEST_N, .CONV_EOC,
  .CONV_ALE, .CONV_START, .CONV_OE, .CONV_CHAN);
`default_nettype wire

//--- test/adc_conv_model.sv
// Purpose: behavioural converter at the far side of the glue
// Assumes: converter clock is the bench clock
// Notes: conversion time is a plain parameter, not a real figure
`timescale 1ns/100ps
`default_nettype none
module adc_conv_model #(
  parameter int CONV_CYCLES = 40
) (
  input wire logic clk,
  input wire logic ale,
  input wire logic start,
  input wire logic oe,
  input wire logic [3:0] chan,
  output logic eoc,
  output logic [7:0] data
);
  logic [3:0] chan_r; // latched channel
  logic ale_q, start_q;
  int busy_r; // cycles left in a conversion
  logic [7:0] last_r; // last driven value
  initial begin
    eoc = 1'b1;
    chan_r = 4'h0;
    ale_q = 1'b0;
    start_q = 1'b0;
    busy_r = 0;
    last_r = 8'h00;
  end
  // channel on latch rise, conversion from start fall
  always @(posedge clk) begin
    ale_q <= ale;
    start_q <= start;
    if (ale && !ale_q) chan_r <= chan;
    if (!start && start_q) begin
      eoc <= 1'b0;
      busy_r <= CONV_CYCLES;
    end else if (busy_r > 1) begin
      busy_r <= busy_r - 1;
    end else if (busy_r == 1) begin
      busy_r <= 0;
      eoc <= 1'b1;
    end
    if (oe) last_r <= {4'h5, chan_r};
  end
  // a released bus shows the inverse, never a stale copy
  assign data = oe ? {4'h5, chan_r} : ~last_r;
endmodule
`default_nettype wire

//--- test/cpu_adc_bus_interface_test.sv
// Purpose: directed scenarios for the converter bus glue
// Assumes: straps set only inside reset
// Notes: each pulse is counted over a window, length must match the strobe
`timescale 1ns/100ps
`default_nettype none
module cpu_adc_bus_interface_test
  import adc_glue_pkg::*;
;
  logic clk, rst_b, rd_n, wr_n, io_m, rw, phi2, valid_memory_cycle, ack_n;
  logic [4:0] straps; // mem, ext, direct, qualify, chan from addr
  logic [15:0] addr;
  logic [7:0] din, dout, cdata, seen_data, seen_stat;
  logic doe_n, irq_n, eoc, ale, start, oe;
  logic [3:0] chan;
  logic [3:0] tbl [8] = '{4'h8, 4'h1, 4'h4, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  cpu_adc_bus_interface cpu_adc_bus_interface_i (.CORE_CLK(clk), .RST_B(rst_b),
    .MODE_MEM(straps[4]), .MEM_EXTENDED(straps[3]), .IRQ_DIRECT(straps[2]),
    .ACK_QUALIFY(straps[1]), .CHAN_FROM_ADDR(straps[0]), .CPU_ADDR(addr), .CPU_RD_N(rd_n),
    .CPU_WR_N(wr_n), .CPU_IO_M(io_m), .CPU_RW(rw), .PHI2(phi2), .VALID_MEMORY_CYCLE(valid_memory_cycle),
    .CPU_DATA_IN(din), .CPU_DATA_OUT(dout), .CPU_DATA_OE_N(doe_n),
    .CPU_INTERRUPT_ACK_N(ack_n), .CPU_INTERRUPT_REQUEST_N(irq_n), .CONV_EOC(eoc),
    .CONV_ALE(ale), .CONV_START(start), .CONV_OE(oe), .CONV_CHAN(chan));
  adc_conv_model adc_conv_model_i (.clk(clk), .ale(ale), .start(start), .oe(oe),
    .chan(chan), .eoc(eoc), .data(cdata));
  initial begin // converter clock comes from the bench too
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset(input logic [4:0] s);
    rst_b <= 1'b0;
    straps <= s;
    tick(8);
    rst_b <= 1'b1;
    tick(1);
  endtask
  // one bus cycle, strobe three cycles long; e = ale, start, oe, status
  task automatic bus(input logic mem, input logic r, input logic v, input logic [15:0] a,
                     input logic [7:0] d, input logic [3:0] e);
    int na, ns, no, nt;
    na = 0;
    ns = 0;
    no = 0;
    nt = 0;
    seen_data = 8'h00; // stale captures must not satisfy a later compare
    seen_stat = 8'h00;
    addr <= a;
    din <= d;
    rw <= r;
    tick(2);
    if (mem) begin
      phi2 <= 1'b1;
      valid_memory_cycle <= v;
    end else begin
      io_m <= v;
      rd_n <= !r;
      wr_n <= r;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      if (i == 2) begin
        phi2 <= 1'b0;
        valid_memory_cycle <= 1'b0;
        io_m <= 1'b0;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
      end
      #1;
      na += ale;
      ns += start;
      no += oe;
      nt += !doe_n;
      if (oe) seen_data = cdata;
      if (!doe_n) seen_stat = dout;
    end
    check(8'(na), e[3] ? 8'h03 : 8'h00);
    check(8'(ns), e[2] ? 8'h03 : 8'h00);
    check(8'(no), e[1] ? 8'h03 : 8'h00);
    check(8'(nt), e[0] ? 8'h03 : 8'h00);
    // return on an edge so the next drive lands on one
    @(posedge clk);
  endtask
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 200 && irq_n !== v; i++) tick(1);
    check({7'h00, irq_n}, {7'h00, v});
  endtask
  task automatic ack_pulse;
    ack_n <= 1'b0;
    tick(3);
    ack_n <= 1'b1;
    tick(1);
  endtask
  task automatic t_io;
    do_reset(5'b00001);
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, k[0], 1'b1, {k[2:1], 14'h0b00}, 8'h00, tbl[k]);
    end
    bus(1'b0, 1'b1, 1'b0, 16'h4000, 8'h00, 4'h0);
    bus(1'b0, 1'b0, 1'b1, 16'h0900, 8'h00, 4'h8);
    check({4'h0, chan}, 8'h09);
  endtask
  task automatic t_mem;
    do_reset(5'b10001);
    bus(1'b1, 1'b0, 1'b1, 16'hf12a, 8'h00, 4'hc);
    bus(1'b1, 1'b1, 1'b1, 16'hf12a, 8'h00, 4'h2);
    check(seen_data, 8'h5a);
    bus(1'b1, 1'b0, 1'b1, 16'he12a, 8'h00, 4'h0);
    bus(1'b1, 1'b0, 1'b0, 16'hf12a, 8'h00, 4'h0);
  endtask
  task automatic t_ext;
    do_reset(5'b11000);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, k[0], 1'b1, {10'h3c0, k[2:1], 4'h5}, 8'h00, tbl[k]);
    end
    bus(1'b1, 1'b0, 1'b1, 16'hf800, 8'h0b, 4'h0);
    bus(1'b1, 1'b0, 1'b1, 16'hf7c0, 8'h07, 4'h8);
    check({4'h0, chan}, 8'h07);
  endtask
  task automatic t_irq;
    do_reset(5'b00001);
    bus(1'b0, 1'b0, 1'b1, 16'h4000, 8'h00, 4'h4);
    wait_irq(1'b0);
    ack_pulse();
    wait_irq(1'b1);
    bus(1'b0, 1'b0, 1'b1, 16'h4000, 8'h00, 4'h4);
    wait_irq(1'b0);
    bus(1'b0, 1'b1, 1'b1, 16'h0000, 8'h00, 4'h1);
    check({7'h00, irq_n}, 8'h01);
    check(seen_stat, 8'h01);
  endtask
  task automatic t_qual;
    do_reset(5'b00011);
    bus(1'b0, 1'b0, 1'b1, 16'h4000, 8'h00, 4'h4);
    wait_irq(1'b0);
    bus(1'b0, 1'b0, 1'b1, 16'h4000, 8'h00, 4'h4);
    tick(4);
    ack_pulse();
    tick(4);
    check({7'h00, irq_n}, 8'h00);
    tick(40);
    ack_pulse();
    wait_irq(1'b1);
  endtask
  task automatic t_direct;
    do_reset(5'b00101);
    tick(4);
    check({7'h00, irq_n}, 8'h00);
    bus(1'b0, 1'b0, 1'b1, 16'h4000, 8'h00, 4'h4);
    tick(3);
    check({7'h00, irq_n}, 8'h01);
    wait_irq(1'b0);
  endtask
  // hang guard, well above the several hundred cycles of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    rst_b = 1'b0;
    straps = 5'h00;
    addr = 16'h0000;
    din = 8'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
    io_m = 1'b0;
    rw = 1'b0;
    phi2 = 1'b0;
    valid_memory_cycle = 1'b0;
    ack_n = 1'b1;
    seen_data = 8'h00;
    seen_stat = 8'h00;
    @(posedge clk);
    t_io();
    t_mem();
    t_ext();
    t_irq();
    t_qual();
    t_direct();
    give_verdict();
  end
endmodule
`default_nettype wire
